// file: hdl/cgc_general_control.sv
// General control register and mode logic of the CAN controller
`timescale 1ns/1ps
// How it works
// RQ1: Abort bit clears all object enables, sticky
// RQ2: Abort cancels pending; current frame completes
// RQ3: Overload bit self-clears at overload start
// RQ4: Bit 5 selects time-triggered operation
// RQ5: Bit 4 picks capture at EOF or SOF
// RQ6: Bit 3 selects listening mode
// RQ7: Software keeps factory test bit cleared
// RQ8: Enable bit enables controller, ungates clock
// RQ9: Disable waits frame end, then freezes
// RQ10: Standby: tx recessive, rx off, clock stopped
// RQ11: Registers stay accessible while disabled
// RQ12: Engine starts three clocks after enable
// RQ13: Soft reset ORed with hardware reset
// RQ14: Controller comes up disabled after reset
// RQ15: Control register resets to zero
// RQ16: Status flag shows true enable state
// RQ17: Listen: no ack, no tx, counters frozen
// RQ18: Timer captured into capture pair
// RQ19: Time-triggered frames sent only once
// RQ20: Soft reset bit reads zero next cycle
module cgc_general_control #(
    parameter int MSG_OBJECTS = 4,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire cgc_pkg::cgc_bus_t i_bus,
    output logic [7:0] o_rdata,
    input wire cgc_pkg::cgc_proto_t i_proto,
    input wire logic [MSG_OBJECTS-1:0] i_obj_enable,
    output logic [MSG_OBJECTS-1:0] o_obj_enable_clr,
    input wire logic [TIMER_WIDTH-1:0] i_timer,
    output logic [TIMER_WIDTH-1:0] o_trigger_capture,
    input wire logic i_rx_pin,
    output logic o_tx_pin,
    input wire logic i_proto_tx,
    output logic o_rx_to_proto,
    output logic o_can_clk_en,
    output logic o_ctrl_rst,
    output logic o_enable_state_flag,
    output cgc_pkg::cgc_ctrl_t o_ctrl
);
    // ****************************************
    // State
    // ****************************************
    typedef enum {
        CGC_OFF,
        CGC_STARTING,
        CGC_RUN,
        CGC_STOPPING
    } cgc_state_t;

    cgc_state_t state;
    cgc_state_t next_state;
    logic [7:0] general_control_reg;
    logic [7:0] next_general_control_reg;
    logic soft_reset;
    logic next_soft_reset;
    logic [TIMER_WIDTH-1:0] next_capture;
    logic rx_meta;
    logic rx_sync;
    logic start_ready;
    logic ctl_write;
    logic abort_all_request;
    logic overload_frame_request;
    logic time_triggered_mode;
    logic capture_on_frame_end;
    logic controller_enable_bit;
    logic capture_hit;

    assign ctl_write = i_bus.we &&
        (i_bus.addr == cgc_pkg::GENERAL_CONTROL_ADDR);
    assign abort_all_request = general_control_reg[cgc_pkg::ABORT_BIT];
    assign overload_frame_request = general_control_reg[cgc_pkg::OVERLOAD_BIT];
    assign time_triggered_mode = general_control_reg[cgc_pkg::TTC_BIT];
    assign capture_on_frame_end = general_control_reg[cgc_pkg::SYNC_BIT];
    assign controller_enable_bit = general_control_reg[cgc_pkg::ENABLE_BIT];

    // ****************************************
    // Control register
    // ****************************************
    always_comb
    begin
        next_general_control_reg = general_control_reg;
        next_soft_reset = 1'b0;
        if (soft_reset) // [RQ13]
        begin
            next_general_control_reg = cgc_pkg::GENERAL_CONTROL_RESET;
        end
        else
        begin
            // Writable in every state [RQ11]
            if (ctl_write)
            begin
                next_general_control_reg = i_bus.wdata;
                next_general_control_reg[cgc_pkg::RESET_BIT] = 1'b0; // [RQ20]
                next_soft_reset = i_bus.wdata[cgc_pkg::RESET_BIT]; // [RQ13]
            end
            // Hardware clear wins only when no new request is written
            if (i_proto.overload_start &&
                !(ctl_write && i_bus.wdata[cgc_pkg::OVERLOAD_BIT])) // [RQ3]
            begin
                next_general_control_reg[cgc_pkg::OVERLOAD_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            general_control_reg <= cgc_pkg::GENERAL_CONTROL_RESET; // [RQ15]
            soft_reset <= 1'b0;
        end
        else
        begin
            general_control_reg <= next_general_control_reg;
            soft_reset <= next_soft_reset;
        end
    end

    // Soft reset joined with hardware reset for the controller core
    assign o_ctrl_rst = !i_rst_n || soft_reset; // [RQ13]

    // ****************************************
    // Enable sequencing
    // ****************************************
    cgc_start_delay #(
        .PERIODS(cgc_pkg::START_PERIODS)
    ) u_start (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_sync_rst(soft_reset),
        .i_go(state == CGC_STARTING),
        .o_ready(start_ready)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            CGC_OFF:
            begin
                if (controller_enable_bit)
                begin
                    next_state = CGC_STARTING; // [RQ8]
                end
            end
            CGC_STARTING:
            begin
                if (!controller_enable_bit)
                begin
                    next_state = CGC_OFF;
                end
                else if (start_ready)
                begin
                    next_state = CGC_RUN; // [RQ12]
                end
            end
            CGC_RUN:
            begin
                if (!controller_enable_bit)
                begin
                    next_state = CGC_STOPPING;
                end
            end
            CGC_STOPPING:
            begin
                if (controller_enable_bit)
                begin
                    next_state = CGC_RUN;
                end
                else if (!i_proto.frame_busy)
                begin
                    next_state = CGC_OFF; // [RQ9]
                end
            end
            default:
            begin
                next_state = CGC_OFF;
            end
        endcase
        if (soft_reset)
        begin
            next_state = CGC_OFF; // [RQ14]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= CGC_OFF; // [RQ14]
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************
    // Capture and pin logic
    // ****************************************
    assign capture_hit = time_triggered_mode && (state == CGC_RUN ||
        state == CGC_STOPPING) && (capture_on_frame_end ?
        i_proto.eof_last : i_proto.sof); // [RQ5]

    always_comb
    begin
        next_capture = o_trigger_capture;
        if (soft_reset)
        begin
            next_capture = '0;
        end
        else if (capture_hit)
        begin
            next_capture = i_timer; // [RQ18]
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_trigger_capture <= '0;
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            o_trigger_capture <= next_capture;
            rx_meta <= i_rx_pin;
            rx_sync <= rx_meta;
        end
    end

    // Clock runs while enabled or finishing a frame [RQ8] [RQ10]
    assign o_can_clk_en = (state != CGC_OFF);
    assign o_enable_state_flag = (state == CGC_RUN); // [RQ16]
    // Recessive out, receiver blind in standby [RQ10] [RQ17]
    assign o_tx_pin = (state == CGC_OFF) ||
        general_control_reg[cgc_pkg::LISTEN_BIT] || i_proto_tx;
    assign o_rx_to_proto = (state == CGC_OFF) ? 1'b1 : rx_sync;

    // Clears every object enable; busy frame finishes [RQ1] [RQ2]
    assign o_obj_enable_clr = abort_all_request ? i_obj_enable : '0;

    always_comb
    begin
        o_ctrl = '0;
        o_ctrl.run = (state == CGC_RUN) || (state == CGC_STOPPING); // [RQ9]
        o_ctrl.abort_all = abort_all_request; // [RQ2]
        o_ctrl.overload_req = overload_frame_request; // [RQ3]
        o_ctrl.listen_only = general_control_reg[cgc_pkg::LISTEN_BIT]; // [RQ6]
        o_ctrl.no_ack = general_control_reg[cgc_pkg::LISTEN_BIT]; // [RQ17]
        o_ctrl.freeze_err_cnt = general_control_reg[cgc_pkg::LISTEN_BIT];
        o_ctrl.no_retx = time_triggered_mode; // [RQ4] [RQ19]
        o_ctrl.test_mode = general_control_reg[cgc_pkg::TEST_BIT]; // [RQ7]
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb
    begin
        o_rdata = 8'h00;
        if (i_bus.re && i_bus.addr == cgc_pkg::GENERAL_CONTROL_ADDR)
        begin
            o_rdata = general_control_reg;
        end
    end
endmodule

// file: hdl/cgc_pkg.sv
// Package for the CAN general control block
package cgc_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] GENERAL_CONTROL_ADDR = 8'hAB;
    localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h00;
    localparam int ABORT_BIT = 7;
    localparam int OVERLOAD_BIT = 6;
    localparam int TTC_BIT = 5;
    localparam int SYNC_BIT = 4;
    localparam int LISTEN_BIT = 3;
    localparam int TEST_BIT = 2;
    localparam int ENABLE_BIT = 1;
    localparam int RESET_BIT = 0;
    localparam int STATUS_ENABLE_BIT = 2;
    // Start delay of the protocol engine after enable
    localparam int START_PERIODS = 2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cgc_bus_t;

    typedef struct packed {
        logic sof;
        logic eof_last;
        logic frame_busy;
        logic rx_done;
        logic tx_done;
        logic overload_start;
    } cgc_proto_t;

    typedef struct packed {
        logic run;
        logic abort_all;
        logic overload_req;
        logic listen_only;
        logic no_ack;
        logic no_retx;
        logic freeze_err_cnt;
        logic test_mode;
    } cgc_ctrl_t;
endpackage

// file: hdl/cgc_start_delay.sv
// Start delay counter for the protocol engine
`timescale 1ns/1ps
module cgc_start_delay #(
    parameter int PERIODS = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_sync_rst,
    input wire logic i_go,
    output logic o_ready
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    always_comb
    begin
        next_cnt = cnt;
        if (i_sync_rst || !i_go)
        begin
            next_cnt = 4'h0;
        end
        else if (cnt < 4'(PERIODS - 1))
        begin
            next_cnt = cnt + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= 4'h0;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    // Ready in the last of PERIODS cycles, so the move follows at once
    assign o_ready = i_go && (cnt == 4'(PERIODS - 1));
endmodule

// file: tb/cgc_bus_node.sv
// Model of the other nodes on the CAN bus
`timescale 1ns/1ps
module cgc_bus_node (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    output cgc_pkg::cgc_proto_t o_proto,
    output logic o_rx_pin,
    output logic [15:0] o_timer,
    output logic [15:0] o_sof_time,
    output logic [15:0] o_eof_time
);
    logic [4:0] cnt;
    logic adv;
    assign adv = (cnt != 5'h00 || i_go) && cnt != 5'h14;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= 5'h00;
            o_proto <= '0;
            o_rx_pin <= 1'b1;
            o_timer <= 16'h0000;
            o_sof_time <= 16'h0000;
            o_eof_time <= 16'h0000;
        end
        else
        begin
            o_timer <= o_timer + 16'h0001;
            if (o_proto.sof)
                o_sof_time <= o_timer;
            if (o_proto.eof_last)
                o_eof_time <= o_timer;
            o_proto.sof <= i_go && cnt == 5'h00;
            o_proto.frame_busy <= adv;
            o_proto.eof_last <= cnt == 5'h13;
            o_proto.rx_done <= cnt == 5'h13;
            o_proto.tx_done <= 1'b0;
            o_proto.overload_start <= cnt == 5'h14;
            // Recessive between frames
            o_rx_pin <= (cnt != 5'h00) ? o_timer[0] : 1'b1;
            cnt <= adv ? cnt + 5'h01 : 5'h00;
        end
    end
endmodule

// file: tb/cgc_general_control_monitor.sv
// Assertion checker for the CAN general control block
`timescale 1ns/1ps
module cgc_general_control_monitor #(
    parameter int MSG_OBJECTS = 4,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire cgc_pkg::cgc_bus_t i_bus,
    input wire logic [7:0] o_rdata,
    input wire cgc_pkg::cgc_proto_t i_proto,
    input wire logic [MSG_OBJECTS-1:0] i_obj_enable,
    input wire logic [MSG_OBJECTS-1:0] o_obj_enable_clr,
    input wire logic [TIMER_WIDTH-1:0] i_timer,
    input wire logic [TIMER_WIDTH-1:0] o_trigger_capture,
    input wire logic i_rx_pin,
    input wire logic o_tx_pin,
    input wire logic i_proto_tx,
    input wire logic o_rx_to_proto,
    input wire logic o_can_clk_en,
    input wire logic o_ctrl_rst,
    input wire logic o_enable_state_flag,
    input wire cgc_pkg::cgc_ctrl_t o_ctrl
);
    logic wr;
    assign wr = i_bus.we && i_bus.addr == cgc_pkg::GENERAL_CONTROL_ADDR;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ****
    // Assertions
    // ****
    chk_abort_clear: assert property (
        o_obj_enable_clr == (o_ctrl.abort_all ? i_obj_enable : '0))
        else $error("object clear does not follow abort");
    chk_abort_sticky: assert property (
        o_ctrl.abort_all && !wr && !o_ctrl_rst |=> o_ctrl.abort_all)
        else $error("abort bit dropped by itself");
    chk_overload_clear: assert property (
        o_ctrl.overload_req && i_proto.overload_start && !wr
        |=> !o_ctrl.overload_req)
        else $error("overload request not cleared");
    chk_start_delay: assert property (
        wr && i_bus.wdata[1] && !i_bus.wdata[0] && !o_can_clk_en
        && !o_ctrl_rst |=> !o_enable_state_flag [*3] ##1 o_enable_state_flag)
        else $error("start delay wrong");
    chk_stop_wait: assert property (
        wr && !i_bus.wdata[1] && o_enable_state_flag && i_proto.frame_busy
        |=> o_can_clk_en)
        else $error("stopped during a frame");
    chk_soft_reset: assert property (
        wr && i_bus.wdata[0]
        |=> o_ctrl_rst ##1 (!o_can_clk_en && !o_enable_state_flag))
        else $error("soft reset wrong");
    chk_standby_pins: assert property (
        !o_can_clk_en |-> o_tx_pin && o_rx_to_proto && !o_enable_state_flag)
        else $error("standby pins wrong");
    chk_listen_quiet: assert property (
        o_ctrl.listen_only |-> o_tx_pin && o_ctrl.no_ack
        && o_ctrl.freeze_err_cnt)
        else $error("listen mode not quiet");
    chk_capture_hold: assert property (
        !o_ctrl.no_retx && !o_ctrl_rst |=> $stable(o_trigger_capture))
        else $error("capture outside time trigger");
    chk_reset_bit_zero: assert property (
        i_bus.re && i_bus.addr == cgc_pkg::GENERAL_CONTROL_ADDR
        |-> !o_rdata[0])
        else $error("reset bit reads one");
    cover property ($rose(o_enable_state_flag));
    cover property (o_ctrl.overload_req && i_proto.overload_start);
    cover property (o_ctrl.no_retx && i_proto.sof);
endmodule
bind cgc_general_control cgc_general_control_monitor #(
    .MSG_OBJECTS(MSG_OBJECTS),
    .TIMER_WIDTH(TIMER_WIDTH)
) cgc_general_control_monitor_inst (.i_sys_clk, .i_rst_n, .i_bus,
    .o_rdata, .i_proto, .i_obj_enable, .o_obj_enable_clr, .i_timer,
    .o_trigger_capture, .i_rx_pin, .o_tx_pin, .i_proto_tx, .o_rx_to_proto,
    .o_can_clk_en, .o_ctrl_rst, .o_enable_state_flag, .o_ctrl);

// file: tb/cgc_general_control_tb.sv
// Testbench for the CAN general control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_fail++; $display("wrong value %s exp %h got %h", n, e, g); end end
module cgc_general_control_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic go = 1'b0;
    logic i_proto_tx = 1'b1;
    logic [3:0] i_obj_enable = 4'h0;
    cgc_pkg::cgc_bus_t i_bus = '0;
    cgc_pkg::cgc_proto_t i_proto;
    cgc_pkg::cgc_ctrl_t o_ctrl;
    logic [3:0] o_obj_enable_clr;
    logic [15:0] i_timer, o_trigger_capture, t_sof, t_eof, keep;
    logic [15:0] seed = 16'h610A;
    logic [7:0] o_rdata, rv, d;
    logic i_rx_pin, o_tx_pin, o_rx_to_proto, o_can_clk_en, o_ctrl_rst;
    logic o_enable_state_flag;
    int n_fail = 0;
    int n_compared = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    cgc_general_control cgc_general_control_inst (.i_sys_clk, .i_rst_n,
        .i_bus, .o_rdata, .i_proto, .i_obj_enable, .o_obj_enable_clr,
        .i_timer, .o_trigger_capture, .i_rx_pin, .o_tx_pin, .i_proto_tx,
        .o_rx_to_proto, .o_can_clk_en, .o_ctrl_rst, .o_enable_state_flag,
        .o_ctrl);
    cgc_bus_node cgc_bus_node_inst (.i_clk(i_sys_clk), .i_rst_n,
        .i_go(go), .o_proto(i_proto), .o_rx_pin(i_rx_pin),
        .o_timer(i_timer), .o_sof_time(t_sof), .o_eof_time(t_eof));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] v);
        return v & 8'hFE;
    endfunction
    task automatic wr(input logic [7:0] v);
        @(posedge i_sys_clk) i_bus <= {2'b10, cgc_pkg::GENERAL_CONTROL_ADDR, v};
        @(posedge i_sys_clk) i_bus <= '0;
    endtask
    task automatic rd(output logic [7:0] v);
        @(posedge i_sys_clk);
        i_bus <= {2'b01, cgc_pkg::GENERAL_CONTROL_ADDR, 8'h00};
        @(posedge i_sys_clk) v = o_rdata;
        i_bus <= '0;
    endtask
    task automatic frame(input int n);
        @(posedge i_sys_clk) go <= 1'b1;
        @(posedge i_sys_clk) go <= 1'b0;
        repeat (n) @(posedge i_sys_clk);
    endtask
    task automatic results;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #20000;
        n_fail++;
        results();
    end
    initial
    begin
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(rv);
        `CHK("reset reg", 8'h00, rv)
        `CHK("reset flag", 1'b0, o_enable_state_flag)
        for (int k = 0; k < 24; k++)
        begin
            seed = lfsr(seed);
            d = seed[7:0] & 8'hFA;
            i_obj_enable <= seed[11:8];
            i_proto_tx <= seed[12];
            wr(d);
            rd(rv);
            `CHK("reg", exp_reg(d), rv)
            `CHK("clr", d[7] ? i_obj_enable : 4'h0, o_obj_enable_clr)
            `CHK("modes", {d[7:5], d[3:2]}, {o_ctrl.abort_all, o_ctrl.overload_req, o_ctrl.no_retx, o_ctrl.listen_only, o_ctrl.test_mode})
        end
        wr(8'h00);
        wr(8'h02);
        repeat (2) @(posedge i_sys_clk);
        #1 `CHK("start flag", 1'b0, o_enable_state_flag)
        @(posedge i_sys_clk);
        #1 `CHK("run flag", 1'b1, o_enable_state_flag)
        `CHK("clk en", 1'b1, o_can_clk_en)
        `CHK("run ctrl", 1'b1, o_ctrl.run)
        @(posedge i_sys_clk) i_proto_tx <= 1'b0;
        wr(8'h0A);
        #1 `CHK("listen tx", 1'b1, o_tx_pin)
        wr(8'h02);
        #1 `CHK("normal tx", 1'b0, o_tx_pin)
        wr(8'h22);
        frame(24);
        `CHK("sof cap", t_sof, o_trigger_capture)
        wr(8'h32);
        frame(24);
        `CHK("eof cap", t_eof, o_trigger_capture)
        keep = o_trigger_capture;
        wr(8'h02);
        frame(24);
        `CHK("no cap", keep, o_trigger_capture)
        wr(8'h42);
        frame(24);
        rd(rv);
        `CHK("overload", 8'h02, rv)
        i_obj_enable <= 4'hD;
        wr(8'h82);
        frame(4);
        wr(8'h80);
        @(posedge i_sys_clk);
        #1 `CHK("stopping", 1'b1, o_can_clk_en)
        repeat (24) @(posedge i_sys_clk);
        #1 `CHK("standby clk", 1'b0, o_can_clk_en)
        `CHK("standby rx", 1'b1, o_rx_to_proto)
        `CHK("abort clr", 4'hD, o_obj_enable_clr)
        rd(rv);
        `CHK("abort reg", 8'h80, rv)
        wr(8'h22);
        repeat (4) @(posedge i_sys_clk);
        wr(8'h01);
        #1 `CHK("soft rst", 1'b1, o_ctrl_rst)
        rd(rv);
        `CHK("after rst", 8'h00, rv)
        `CHK("after flag", 1'b0, o_enable_state_flag)
        results();
    end
endmodule
